// ---- logic/host_bus_control_pins.sv ----
// Host bus control pins: address decode, cycle stretching, strap mode, interrupt pin,
// and a Wishbone register file. Assumes host pins are sampled synchronously on core_clk
// and that open-drain pins have external pull-ups; the bench resolves them from the enables.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`include "host_ctrl_map.svh"
`timescale 1ns/100ps
`default_nettype none
module host_bus_control_pins (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire host_ctrl_pkg::host_pins_t pins,
    output host_ctrl_pkg::host_drive_t drive,
    output logic local_select_out_n,
    output logic irq
);
    import host_ctrl_pkg::*;

    // a hit compares A15-A4 against the programmed base
    function automatic logic addr_hit(input logic [15:1] a, input logic qual_n, input logic [15:0] base);
        addr_hit = !qual_n && (a[15:4] == base[15:4]);
    endfunction : addr_hit

    logic [15:0] base_ff, nxt_base;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [2:0] status_ff, nxt_status;
    logic [2:0] mask_ff, nxt_mask;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;
    logic strap_taken_ff, nxt_strap_taken;
    bus_mode_t mode_ff, nxt_mode;
    logic [15:1] lat_addr_ff, nxt_lat_addr;
    logic lat_qual_n_ff, nxt_lat_qual_n;
    logic ads_prev_ff, nxt_ads_prev;
    acc_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic dir_wr_ff, nxt_dir_wr;
    host_drive_t drive_ff, nxt_drive;
    logic irq_ff, nxt_irq;

    logic bus_req;
    logic bus_wr;
    logic live_hit;
    logic use_hit;
    logic start;
    logic start_wr;
    logic done;
    logic [2:0] ev;
    logic [2:0] pend;

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign bus_wr = bus_req && wb_we_i;

    // decode straight from the pins, so the select has no clock latency
    assign live_hit = addr_hit(pins.addr, pins.addr_qualifier_n, base_ff);
    assign local_select_out_n = !live_hit;

    // accesses may decode on the latched copy when the host multiplexes its address
    assign use_hit = ctrl_ff[`CTRL_LATCH_BIT] ? addr_hit(lat_addr_ff, lat_qual_n_ff, base_ff) : live_hit;

    // access start and direction per bus mode
    always_comb begin
        start = 1'b0;
        start_wr = 1'b0;
        case (mode_ff)
            MODE_ASYNC: begin
                start = use_hit && !pins.read_strobe_n;
                start_wr = 1'b0;
            end
            MODE_BURST: begin
                start = use_hit && !pins.addr_strobe_n;
                start_wr = !pins.command_phase_n;
            end
            default: begin
                start = use_hit && !pins.command_phase_n;
                start_wr = pins.sync_write_not_read;
            end
        endcase
    end

    // strap caught on the first edge after reset release, then frozen
    always_comb begin
        nxt_strap_taken = 1'b1;
        nxt_mode = mode_ff;
        if (!strap_taken_ff) begin
            if (pins.bus_mode_strap) begin
                nxt_mode = ctrl_ff[`CTRL_BURST_BIT] ? MODE_BURST : MODE_ASYNC;
            end else begin
                nxt_mode = MODE_SYNC;
            end
        end
    end

    // address latch on rising edge of the address strobe
    always_comb begin
        nxt_ads_prev = pins.addr_strobe_n;
        nxt_lat_addr = lat_addr_ff;
        nxt_lat_qual_n = lat_qual_n_ff;
        if (pins.addr_strobe_n && !ads_prev_ff) begin
            nxt_lat_addr = pins.addr;
            nxt_lat_qual_n = pins.addr_qualifier_n;
        end
    end

    // access sequencer: stretch by the programmed wait count, then signal ready
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_dir_wr = dir_wr_ff;
        done = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_state = ST_WAIT;
                    nxt_cnt = ctrl_ff[`CTRL_WAIT_MSB:`CTRL_WAIT_LSB];
                    nxt_dir_wr = start_wr;
                end
            end
            ST_WAIT: begin
                if (cnt_ff == 4'h0) begin
                    nxt_state = ST_READY;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            ST_READY: begin
                case (mode_ff)
                    MODE_ASYNC: done = pins.read_strobe_n;
                    MODE_BURST: done = pins.host_ready_return_n;
                    default: done = dir_wr_ff || !pins.host_ready_return_n;
                endcase
                if (done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // pin drive: all open-drain pins only ever pull low
    always_comb begin
        nxt_drive.irq_out_n = 1'b0;
        nxt_drive.irq_out_oe = |pend;
        nxt_drive.async_ready_out = 1'b0;
        nxt_drive.async_ready_oe = (mode_ff == MODE_ASYNC) && (nxt_state == ST_WAIT || (state_ff == ST_IDLE && start));
        case (mode_ff)
            MODE_BURST: nxt_drive.sync_ready_out_n = !(nxt_state == ST_WAIT);
            MODE_SYNC: nxt_drive.sync_ready_out_n = !(nxt_state == ST_READY);
            default: nxt_drive.sync_ready_out_n = 1'b1;
        endcase
        nxt_irq = |pend;
    end

    // events: completed read, completed write, latched address that decodes to us
    assign ev[`EV_RD_BIT] = done && (state_ff == ST_READY) && !dir_wr_ff;
    assign ev[`EV_WR_BIT] = done && (state_ff == ST_READY) && dir_wr_ff;
    assign ev[`EV_LATCH_BIT] = pins.addr_strobe_n && !ads_prev_ff && addr_hit(pins.addr, pins.addr_qualifier_n, base_ff);
    // status from next value keeps the pin in step with the sticky bits
    assign pend = nxt_status & mask_ff;

    // register file; a set in the clearing cycle survives the write-one-to-clear
    always_comb begin
        nxt_base = base_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        nxt_status = status_ff | ev;
        nxt_ack = bus_req;
        nxt_rdata = 32'h0;
        if (bus_wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                `REG_BASE_OFF: nxt_base[7:0] = wb_dat_i[7:0];
                `REG_CTRL_OFF: nxt_ctrl = wb_dat_i[7:0];
                `REG_STATUS_OFF: nxt_status = (status_ff & ~wb_dat_i[2:0]) | ev;
                `REG_MASK_OFF: nxt_mask = wb_dat_i[2:0];
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        if (bus_wr && wb_sel_i[1] && wb_adr_i == `REG_BASE_OFF) begin
            nxt_base[15:8] = wb_dat_i[15:8];
        end
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `REG_BASE_OFF: nxt_rdata = {16'h0, base_ff};
                `REG_CTRL_OFF: nxt_rdata = {24'h0, ctrl_ff};
                `REG_STATUS_OFF: nxt_rdata = {29'h0, status_ff};
                `REG_MASK_OFF: nxt_rdata = {29'h0, mask_ff};
                `REG_STATE_OFF: nxt_rdata = {28'h0, state_ff, mode_ff};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    // single register stage for everything
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            base_ff <= `BASE_RST;
            ctrl_ff <= `CTRL_RST;
            status_ff <= 3'h0;
            mask_ff <= `MASK_RST;
            rdata_ff <= 32'h0;
            ack_ff <= 1'b0;
            strap_taken_ff <= 1'b0;
            mode_ff <= MODE_SYNC;
            lat_addr_ff <= 15'h0;
            lat_qual_n_ff <= 1'b1;
            ads_prev_ff <= 1'b1;
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            dir_wr_ff <= 1'b0;
            drive_ff <= 5'b00001;
            irq_ff <= 1'b0;
        end else begin
            base_ff <= nxt_base;
            ctrl_ff <= nxt_ctrl;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            strap_taken_ff <= nxt_strap_taken;
            mode_ff <= nxt_mode;
            lat_addr_ff <= nxt_lat_addr;
            lat_qual_n_ff <= nxt_lat_qual_n;
            ads_prev_ff <= nxt_ads_prev;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            dir_wr_ff <= nxt_dir_wr;
            drive_ff <= nxt_drive;
            irq_ff <= nxt_irq;
        end
    end

    assign wb_dat_o = rdata_ff;
    assign wb_ack_o = ack_ff;
    assign drive = drive_ff;
    assign irq = irq_ff;
endmodule : host_bus_control_pins
`default_nettype wire

// ---- logic/host_ctrl_map.svh ----
// Constants for the host bus control block: register offsets, fields, reset values, counts.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
// Function
// - interrupt pin driven low while any status bit enabled in the mask is set, otherwise released.
// - local select asserted when qualifier low and A15-A4 equal programmed base.
// - local select is a pure combinational decode, no flop in its path.
// - asynchronous ready pulled low to stretch cycles, untimed to host clock.
// - strap low or floating selects synchronous bus operation.
// - strap high selects asynchronous or burst bus operation; code always takes asynchronous, as CTRL is at reset when the strap is caught.
// - synchronous ready low gives wait states in burst; falls for ready in VLBus.
// - address and qualifier captured on rising edge of address strobe.
// - synchronous direction input high means write, low means read.
`ifndef HOST_CTRL_MAP_SVH
`define HOST_CTRL_MAP_SVH
`define REG_BASE_OFF 8'h00
`define REG_CTRL_OFF 8'h04
`define REG_STATUS_OFF 8'h08
`define REG_MASK_OFF 8'h0c
`define REG_STATE_OFF 8'h10
`define BASE_RST 16'h0300
`define CTRL_RST 8'h20
`define MASK_RST 3'h0
`define CTRL_BURST_BIT 0
`define CTRL_LATCH_BIT 1
`define CTRL_WAIT_LSB 4
`define CTRL_WAIT_MSB 7
`define EV_RD_BIT 0
`define EV_WR_BIT 1
`define EV_LATCH_BIT 2
`endif

// ---- logic/host_ctrl_pkg.sv ----
// Types shared by the host bus control block.
// Assumes host pins are already synchronous to core_clk.
package host_ctrl_pkg;
    typedef enum logic [1:0] {
        MODE_SYNC = 2'b00,
        MODE_ASYNC = 2'b01,
        MODE_BURST = 2'b10
    } bus_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_READY = 2'b10
    } acc_state_t;
    typedef struct packed {
        logic [15:1] addr;
        logic addr_qualifier_n;
        logic addr_strobe_n;
        logic read_strobe_n;
        logic command_phase_n;
        logic sync_write_not_read;
        logic host_ready_return_n;
        logic bus_mode_strap;
    } host_pins_t;
    typedef struct packed {
        logic irq_out_n;
        logic irq_out_oe;
        logic async_ready_out;
        logic async_ready_oe;
        logic sync_ready_out_n;
    } host_drive_t;
endpackage : host_ctrl_pkg

// ---- test/host_ctrl_sva.sv ----
// Port checker for the host bus control block.
// Assumes CTRL burst select keeps its reset value, so strap high means async.
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_sva (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire host_ctrl_pkg::host_pins_t pins,
    input wire host_ctrl_pkg::host_drive_t drive,
    input wire logic local_select_out_n,
    input wire logic irq
);
    import host_ctrl_pkg::*;
    logic cap_ff;
    logic strap_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // strap copy at the design's capture edge
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cap_ff <= 1'b0;
            strap_ff <= 1'b0;
        end else if (!cap_ff) begin
            cap_ff <= 1'b1;
            strap_ff <= pins.bus_mode_strap;
        end
    end
    a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one cycle pulse");
    a_sel_off: assert property (pins.addr_qualifier_n |-> local_select_out_n)
        else $error("select without qualifier");
    a_sel_comb: assert property (!$stable(local_select_out_n) |-> !$stable(pins) || wb_ack_o)
        else $error("select moved on its own");
    a_irq_pin: assert property (irq |-> drive.irq_out_oe && !drive.irq_out_n)
        else $error("irq pin not pulled low");
    a_async_stretch: assert property ($rose(drive.async_ready_oe) |-> !$past(pins.read_strobe_n)
        ##[1:20] !drive.async_ready_oe)
        else $error("stretch without strobe or too long");
    a_sync_no_stretch: assert property (cap_ff && !strap_ff |-> !drive.async_ready_oe)
        else $error("stretch in sync mode");
    a_strap_high: assert property (cap_ff && strap_ff |-> drive.sync_ready_out_n)
        else $error("sync ready in async mode");
    a_sync_ready: assert property (cap_ff && !strap_ff && !local_select_out_n
        && $fell(pins.command_phase_n) |-> ##[1:20] !drive.sync_ready_out_n)
        else $error("sync ready missing");
    a_ready_hold: assert property ($fell(drive.sync_ready_out_n) && pins.host_ready_return_n
        |=> drive.sync_ready_out_n == $past(pins.sync_write_not_read))
        else $error("ready held wrongly");
endmodule : host_ctrl_sva
`default_nettype wire

// ---- test/host_model.sv ----
// Host CPU model driving the control pins.
// Assumes pins are sampled on core_clk; ready pin pulled up here.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic core_clk,
    output host_ctrl_pkg::host_pins_t pins,
    input wire host_ctrl_pkg::host_drive_t drive
);
    import host_ctrl_pkg::*;
    wire logic ready_pin = drive.async_ready_oe ? drive.async_ready_out : 1'b1;
    // idle: qualifier, strobes and command high, ready return released, strap low
    initial pins = {15'h0180, 7'b1111010};
    // address phase
    task automatic put_addr(input logic [15:0] a, input logic q);
        @(posedge core_clk);
        pins.addr <= a[15:1];
        pins.addr_qualifier_n <= q;
    endtask : put_addr
    // command after addressing; read ends by ready return
    task automatic sync_access(input logic wr);
        int n;
        n = 0;
        @(posedge core_clk);
        pins.sync_write_not_read <= wr;
        pins.command_phase_n <= 1'b0;
        @(posedge core_clk);
        pins.command_phase_n <= 1'b1;
        while (drive.sync_ready_out_n !== 1'b0 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        pins.host_ready_return_n <= wr;
        @(posedge core_clk);
        pins.host_ready_return_n <= 1'b1;
    endtask : sync_access
    // one low pulse on the address strobe; the rising edge latches the address
    task automatic latch_addr;
        @(posedge core_clk);
        pins.addr_strobe_n <= 1'b0;
        @(posedge core_clk);
        pins.addr_strobe_n <= 1'b1;
        @(posedge core_clk);
    endtask : latch_addr
    // strobe held low while the device stretches
    task automatic async_read;
        int n;
        n = 0;
        @(posedge core_clk);
        pins.read_strobe_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        while (ready_pin !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        pins.read_strobe_n <= 1'b1;
    endtask : async_read
endmodule : host_model
`default_nettype wire

// ---- test/test_host_bus_control_pins.sv ----
// Bench: register table, decode, host cycles in sync and async modes, interrupt.
// Assumes host_model drives the pins; irq pin pulled up here.
`include "host_ctrl_map.svh"
`timescale 1ns/100ps
`default_nettype none
module test_host_bus_control_pins;
    import host_ctrl_pkg::*;
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
        logic [31:0] exp;
    } row_t;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic wb_ack_o;
    logic local_select_out_n;
    logic irq;
    host_pins_t pins;
    host_drive_t drive;
    int error_cnt = 0;
    int n_tests = 0;
    wire logic irq_pin = drive.irq_out_oe ? drive.irq_out_n : 1'b1;
    // reset values, mask, unmapped place; state row is strap low
    row_t rows [8] = '{'{1'b0, `REG_BASE_OFF, 32'h0, 32'h300}, '{1'b0, `REG_CTRL_OFF, 32'h0, 32'h20},
        '{1'b0, `REG_MASK_OFF, 32'h0, 32'h0}, '{1'b0, `REG_STATE_OFF, 32'h0, 32'h0},
        '{1'b1, `REG_MASK_OFF, 32'h7, 32'h0}, '{1'b0, `REG_MASK_OFF, 32'h0, 32'h7},
        '{1'b1, 8'h14, 32'h5a, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'h0}};
    always #20 core_clk = ~core_clk;
    host_bus_control_pins host_bus_control_pins_i (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins(pins), .drive(drive),
        .local_select_out_n(local_select_out_n), .irq(irq));
    host_model host_model_i (.core_clk(core_clk), .pins(pins), .drive(drive));
    task automatic conclude;
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one classic cycle; no fixed latency assumed
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk("ack", n < 50, 32'h1);
    endtask : wb
    task automatic do_reset;
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
    endtask : do_reset
    // decode checked in the same cycle as the address change
    task automatic sel(input logic [15:0] a, input logic q, input logic exp);
        host_model_i.put_addr(a, q);
        @(negedge core_clk);
        chk("select", local_select_out_n, exp);
    endtask : sel
    initial begin
        repeat (4000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].adr, rows[i].dat);
            if (!rows[i].we)
                chk("reg", rd, rows[i].exp);
        end
        sel(16'h0305, 1'b0, 1'b0);
        sel(16'h0315, 1'b0, 1'b1);
        sel(16'h0305, 1'b1, 1'b1);
        wb(1'b1, `REG_BASE_OFF, 32'h0450);
        sel(16'h045e, 1'b0, 1'b0);
        host_model_i.sync_access(1'b1);
        host_model_i.sync_access(1'b0);
        wb(1'b0, `REG_STATUS_OFF, 32'h0);
        chk("status", rd, 32'h3);
        chk("irq pin", irq_pin, 32'h0);
        wb(1'b1, `REG_MASK_OFF, 32'h0);
        wb(1'b0, `REG_MASK_OFF, 32'h0);
        chk("irq masked", irq, 32'h0);
        wb(1'b1, `REG_MASK_OFF, 32'h7);
        wb(1'b1, `REG_STATUS_OFF, 32'h1);
        wb(1'b0, `REG_STATUS_OFF, 32'h0);
        chk("w1c", rd, 32'h2);
        chk("irq", irq, 32'h1);
        wb(1'b1, `REG_STATUS_OFF, 32'h2);
        wb(1'b0, `REG_STATUS_OFF, 32'h0);
        chk("irq pin off", irq_pin, 32'h1);
        host_model_i.pins.bus_mode_strap <= 1'b1;
        do_reset();
        wb(1'b0, `REG_STATE_OFF, 32'h0);
        chk("mode", rd, 32'h1);
        host_model_i.pins.bus_mode_strap <= 1'b0;
        sel(16'h0305, 1'b0, 1'b0);
        host_model_i.async_read();
        wb(1'b0, `REG_STATUS_OFF, 32'h0);
        chk("async done", rd, 32'h1);
        wb(1'b0, `REG_STATE_OFF, 32'h0);
        chk("mode held", rd[1:0], 32'h1);
        host_model_i.latch_addr();
        wb(1'b0, `REG_STATUS_OFF, 32'h0);
        chk("latch hit", rd, 32'h5);
        wb(1'b1, `REG_CTRL_OFF, 32'h22);
        wb(1'b1, `REG_STATUS_OFF, 32'h7);
        sel(16'h0315, 1'b0, 1'b1);
        host_model_i.async_read();
        wb(1'b0, `REG_STATUS_OFF, 32'h0);
        chk("latched decode", rd, 32'h1);
        conclude();
    end
endmodule : test_host_bus_control_pins
bind host_bus_control_pins host_ctrl_sva host_ctrl_sva_i (.core_clk(core_clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pins(pins), .drive(drive),
    .local_select_out_n(local_select_out_n), .irq(irq));
`default_nettype wire
